/* hdl/lps_sequencer.sv */
// Light and proximity conversion sequencer with threshold interrupt
// Function
// - After reset the block sits in power-down and converts nothing.
// - Result registers read zero until a conversion completes.
// - One-shot runs one conversion, returns to power-down, keeps result.
// - Continuous repeats conversions and overwrites result each time.
// - Power-down command stops any conversion, continuous included.
// - Six modes: ambient, IR, proximity, each one-shot or continuous.
// - Integration timed by n-bit counter of oscillator ticks, n=4/8/12/16.
// - Result is unsigned n bits, at most sixteen.
// - Proximity turns on emitter drive with programmed current and mode.
// - Modulation bit clear gives steady drive, set gives 360 kHz.
// - Modulated drive is on half of each period.
// - Interrupt pin is active low open drain, only pulls low.
// - Readable status flag mirrors the interrupt.
// - Interrupt when count goes above upper or below lower threshold.
// - Persistence needs repeated out-of-window results before interrupt.
// - Four ranges selectable, applied to following conversions; fe_range_q follows a cmd2 write from the second cycle after it, mid-conversion too.
// - Operation field codes 000..111, code 100 reserved.
// - Persistence field 00,01,10,11 needs 1,4,8,16 results.
// - Interrupt stays until a write to first command register clears.
// - Resolution field sets 65536/4096/256/16 cycles, 16/12/8/4 bits.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module lps_sequencer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_q,
	// Internal oscillator and front end pulses (asynchronous)
	input wire logic osc_clk,
	input wire logic fe_charge_pulse,
	// Front end control
	output logic fe_active_q,
	output logic [1:0] fe_source_q,
	output logic [1:0] fe_range_q,
	output logic fe_scheme_q,
	// Emitter driver
	output logic emitter_drive_pin,
	output logic [1:0] led_current_select,
	// Interrupt pin, open drain
	input wire logic int_n_i,
	output logic int_n_o,
	output logic int_n_oe
);
	import lps_pkg::*;

	typedef enum logic {ST_PDN, ST_CONV} lps_state_e;

	// Asynchronous input synchronisers: osc and charge pulse
	localparam int N_ASYNC = 2;
	logic [N_ASYNC-1:0] async_in;
	logic [N_ASYNC-1:0] sync1_q;
	logic [N_ASYNC-1:0] sync2_q;
	logic [N_ASYNC-1:0] sync3_q;
	logic [N_ASYNC-1:0] filt_q;
	logic [N_ASYNC-1:0] rise;

	assign async_in = {fe_charge_pulse, osc_clk};

	genvar gi;
	generate
		for (gi = 0; gi < N_ASYNC; gi = gi + 1) begin : g_sync
			// Level counts only once stages two and three agree
			assign rise[gi] = (sync2_q[gi] == sync3_q[gi]) &&
				sync3_q[gi] && !filt_q[gi];
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
				end else begin
					sync1_q[gi] <= async_in[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					if (sync2_q[gi] == sync3_q[gi]) begin
						filt_q[gi] <= sync3_q[gi];
					end
				end
			end
		end
	endgenerate

	logic osc_tick;
	logic charge_tick;
	assign osc_tick = rise[0];
	assign charge_tick = rise[1];

	// Registers
	lps_state_e state_q;
	logic [2:0] op_q;
	logic [1:0] prst_q;
	logic [7:0] cmd2_q;
	logic [15:0] data_q;
	logic [15:0] tl_q;
	logic [15:0] th_q;
	logic flag_q;
	logic [4:0] prst_cnt_q;
	logic [16:0] charge_cnt_q;

	// Write decode
	logic wr_cmd1;
	logic wr_cmd2;
	logic [2:0] new_op;
	logic op_valid;
	logic op_cont;
	assign wr_cmd1 = reg_wr && (reg_addr == ADDR_CMD1);
	assign wr_cmd2 = reg_wr && (reg_addr == ADDR_CMD2);
	assign new_op = reg_wdata[OP_LSB+2:OP_LSB];
	// Reserved code acts as power-down
	assign op_valid = (new_op != OP_PDN) && (new_op != OP_RSVD);
	assign op_cont = op_q[2];

	// Command II fields
	logic [1:0] res_sel;
	logic mod_sel;
	assign res_sel = cmd2_q[RES_LSB+1:RES_LSB];
	assign mod_sel = cmd2_q[FREQ_BIT];

	// Timer hookup
	logic conv_start;
	logic conv_abort;
	logic tmr_busy;
	logic tmr_done;
	logic tmr_start;
	logic cont_restart;
	// Any write to the op field restarts or stops the sequence
	assign conv_start = wr_cmd1 && op_valid;
	assign conv_abort = wr_cmd1 && !op_valid;
	// Restart back to back in continuous mode
	assign cont_restart = tmr_done && op_cont && (state_q == ST_CONV) &&
		!wr_cmd1;
	assign tmr_start = conv_start || cont_restart;

	lps_int_timer u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(tmr_start),
		.abort(conv_abort),
		.res_sel(res_sel),
		.osc_tick(osc_tick),
		.busy_q(tmr_busy),
		.done_q(tmr_done)
	);

	// Result clamp to n bits
	logic [16:0] res_max;
	logic [15:0] result;
	assign res_max = (res_sel == 2'h0) ? RES_MAX0 :
		(res_sel == 2'h1) ? RES_MAX1 :
		(res_sel == 2'h2) ? RES_MAX2 : RES_MAX3;
	assign result = (charge_cnt_q > res_max) ? res_max[15:0] :
		charge_cnt_q[15:0];

	// Threshold window and persistence
	logic out_win;
	logic [4:0] prst_need;
	logic [4:0] prst_next;
	logic trig;
	// Above upper or below lower
	assign out_win = (result > th_q) || (result < tl_q);
	assign prst_need = (prst_q == 2'h0) ? PRST_CNT0 :
		(prst_q == 2'h1) ? PRST_CNT1 :
		(prst_q == 2'h2) ? PRST_CNT2 : PRST_CNT3;
	// Saturate so a long run never wraps back below the need
	assign prst_next = (prst_cnt_q == PRST_CNT3) ? prst_cnt_q :
		prst_cnt_q + 5'h1;
	// Consecutive out-of-window count reaches need
	assign trig = tmr_done && out_win && (prst_next >= prst_need);

	// Sequencer state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Power-down from reset
			state_q <= ST_PDN;
			op_q <= OP_PDN;
		end else if (wr_cmd1) begin
			// Stop on power-down, restart on new mode
			op_q <= op_valid ? new_op : OP_PDN;
			state_q <= op_valid ? ST_CONV : ST_PDN;
		end else begin
			case (state_q)
				ST_PDN: begin
					state_q <= ST_PDN;
				end
				ST_CONV: begin
					if (tmr_done && !op_cont) begin
						// One-shot drops back itself
						state_q <= ST_PDN;
						op_q <= OP_PDN;
					end
				end
				default: begin
					state_q <= ST_PDN;
					op_q <= OP_PDN;
				end
			endcase
		end
	end

	// Charge pulse counter over the integration window
	always_ff @(posedge clk_sys) begin
		if (rst || conv_start || cont_restart) begin
			charge_cnt_q <= 17'h0;
		end else if (tmr_busy && charge_tick && !charge_cnt_q[16]) begin
			charge_cnt_q <= charge_cnt_q + 17'h1;
		end
	end

	// Result, persistence and interrupt flag
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Zero until first conversion
			data_q <= DATA_RST;
			prst_cnt_q <= 5'h0;
			flag_q <= 1'b0;
		end else begin
			if (tmr_done && !wr_cmd1) begin
				// Latest result replaces the old one
				data_q <= result;
				// In-window result restarts the count
				prst_cnt_q <= out_win ? prst_next : 5'h0;
			end
			// Set wins over the clear of a cmd1 write
			if (trig) begin
				flag_q <= 1'b1;
			end else if (wr_cmd1) begin
				flag_q <= 1'b0;
			end
		end
	end

	// Remaining writable registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prst_q <= CMD_RST[PRST_LSB+1:PRST_LSB];
			cmd2_q <= CMD_RST;
			tl_q <= TL_RST;
			th_q <= TH_RST;
		end else begin
			if (wr_cmd1) begin
				prst_q <= reg_wdata[PRST_LSB+1:PRST_LSB];
			end
			if (wr_cmd2) begin
				cmd2_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == ADDR_TL_LSB) begin
				tl_q[7:0] <= reg_wdata;
			end
			if (reg_wr && reg_addr == ADDR_TL_MSB) begin
				tl_q[15:8] <= reg_wdata;
			end
			if (reg_wr && reg_addr == ADDR_TH_LSB) begin
				th_q[7:0] <= reg_wdata;
			end
			if (reg_wr && reg_addr == ADDR_TH_MSB) begin
				th_q[15:8] <= reg_wdata;
			end
		end
	end

	// Read mux; flag shows in bit two
	logic [7:0] cmd1_rd;
	logic [7:0] rd_mux;
	assign cmd1_rd = {op_q, 2'b00, flag_q, prst_q};
	assign rd_mux = (reg_addr == ADDR_CMD1) ? cmd1_rd :
		(reg_addr == ADDR_CMD2) ? cmd2_q :
		(reg_addr == ADDR_DATA_LSB) ? data_q[7:0] :
		(reg_addr == ADDR_DATA_MSB) ? data_q[15:8] :
		(reg_addr == ADDR_TL_LSB) ? tl_q[7:0] :
		(reg_addr == ADDR_TL_MSB) ? tl_q[15:8] :
		(reg_addr == ADDR_TH_LSB) ? th_q[7:0] : th_q[15:8];

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= rd_mux;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// Front end control
	logic prx_on;
	logic [1:0] src_d;
	assign prx_on = (state_q == ST_CONV) && (op_q[1:0] == SRC_PRX);
	assign src_d = (state_q == ST_CONV) ? op_q[1:0] : 2'h0;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fe_active_q <= 1'b0;
			fe_source_q <= 2'h0;
			fe_range_q <= 2'h0;
			fe_scheme_q <= 1'b0;
			led_current_select <= 2'h0;
			int_n_oe <= 1'b0;
		end else begin
			fe_active_q <= (state_q == ST_CONV);
			fe_source_q <= src_d;
			// Range takes effect from the next cycle on
			fe_range_q <= cmd2_q[RANGE_LSB+1:RANGE_LSB];
			fe_scheme_q <= cmd2_q[SCHEME_BIT];
			// Programmed current amplitude
			led_current_select <= cmd2_q[IS_LSB+1:IS_LSB];
			// Pull low only while flagged
			int_n_oe <= flag_q;
		end
	end

	// Open drain never drives high
	always_ff @(posedge clk_sys) begin
		int_n_o <= 1'b0;
	end

	// Emitter driver during proximity only
	lps_led_mod u_led (
		.clk_sys(clk_sys),
		.rst(rst),
		.enable(prx_on),
		.mod_en(mod_sel),
		.drive_q(emitter_drive_pin)
	);

endmodule

/* hdl/lps_pkg.sv */
// Constants shared by the light and proximity sequencer
package lps_pkg;

	// Register offsets (8-bit registers)
	localparam logic [2:0] ADDR_CMD1 = 3'h0;
	localparam logic [2:0] ADDR_CMD2 = 3'h1;
	localparam logic [2:0] ADDR_DATA_LSB = 3'h2;
	localparam logic [2:0] ADDR_DATA_MSB = 3'h3;
	localparam logic [2:0] ADDR_TL_LSB = 3'h4;
	localparam logic [2:0] ADDR_TL_MSB = 3'h5;
	localparam logic [2:0] ADDR_TH_LSB = 3'h6;
	localparam logic [2:0] ADDR_TH_MSB = 3'h7;

	// First command register fields
	localparam int OP_LSB = 5;
	localparam int FLAG_BIT = 2;
	localparam int PRST_LSB = 0;

	// Second command register fields
	localparam int SCHEME_BIT = 7;
	localparam int FREQ_BIT = 6;
	localparam int IS_LSB = 4;
	localparam int RES_LSB = 2;
	localparam int RANGE_LSB = 0;

	// Reset values
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [15:0] TL_RST = 16'h0000;
	localparam logic [15:0] TH_RST = 16'hffff;

	// Operation codes
	localparam logic [2:0] OP_PDN = 3'h0;
	localparam logic [2:0] OP_ALS_ONCE = 3'h1;
	localparam logic [2:0] OP_IR_ONCE = 3'h2;
	localparam logic [2:0] OP_PRX_ONCE = 3'h3;
	localparam logic [2:0] OP_RSVD = 3'h4;
	localparam logic [2:0] OP_ALS_CONT = 3'h5;
	localparam logic [2:0] OP_IR_CONT = 3'h6;
	localparam logic [2:0] OP_PRX_CONT = 3'h7;

	// Front end source select
	localparam logic [1:0] SRC_ALS = 2'h1;
	localparam logic [1:0] SRC_IR = 2'h2;
	localparam logic [1:0] SRC_PRX = 2'h3;

	// Persistence counts per code
	localparam logic [4:0] PRST_CNT0 = 5'h01;
	localparam logic [4:0] PRST_CNT1 = 5'h04;
	localparam logic [4:0] PRST_CNT2 = 5'h08;
	localparam logic [4:0] PRST_CNT3 = 5'h10;

	// Oscillator cycles per conversion per resolution code
	localparam logic [16:0] RES_CYC0 = 17'h10000;
	localparam logic [16:0] RES_CYC1 = 17'h01000;
	localparam logic [16:0] RES_CYC2 = 17'h00100;
	localparam logic [16:0] RES_CYC3 = 17'h00010;

	// Largest result per resolution code (16, 12, 8, 4 bits)
	localparam logic [16:0] RES_MAX0 = 17'h0ffff;
	localparam logic [16:0] RES_MAX1 = 17'h00fff;
	localparam logic [16:0] RES_MAX2 = 17'h000ff;
	localparam logic [16:0] RES_MAX3 = 17'h0000f;

	// LED modulation timing
	localparam int CLK_KHZ = 200000;
	localparam int MOD_FREQ_KHZ = 360;
	localparam int MOD_DUTY_PCT = 50;
	localparam int MOD_PERIOD_CYC = CLK_KHZ / MOD_FREQ_KHZ;
	localparam int MOD_ON_CYC = MOD_PERIOD_CYC * MOD_DUTY_PCT / 100;
	localparam int MOD_OFF_CYC = MOD_PERIOD_CYC - MOD_ON_CYC;
	localparam int MOD_CNT_W = 10;

endpackage

/* hdl/lps_int_timer.sv */
// Integration timer counting internal oscillator ticks
`timescale 1ns/100ps
module lps_int_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic abort,
	input wire logic [1:0] res_sel,
	input wire logic osc_tick,
	// Status
	output logic busy_q,
	output logic done_q
);
	import lps_pkg::*;

	logic [16:0] cnt_q;
	logic [16:0] target;
	logic last_tick;

	// n-bit counter length picked by resolution
	assign target = (res_sel == 2'h0) ? RES_CYC0 :
		(res_sel == 2'h1) ? RES_CYC1 :
		(res_sel == 2'h2) ? RES_CYC2 : RES_CYC3;
	assign last_tick = busy_q && osc_tick && (cnt_q == target - 17'h1);

	always_ff @(posedge clk_sys) begin
		if (rst || abort) begin
			cnt_q <= 17'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (start) begin
			cnt_q <= 17'h0;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			done_q <= last_tick;
			if (last_tick) begin
				busy_q <= 1'b0;
			end
			if (busy_q && osc_tick) begin
				cnt_q <= cnt_q + 17'h1;
			end
		end
	end

endmodule

/* hdl/lps_led_mod.sv */
// Emitter drive waveform: steady or 50 percent modulated
`timescale 1ns/100ps
module lps_led_mod (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control
	input wire logic enable,
	input wire logic mod_en,
	// Drive
	output logic drive_q
);
	import lps_pkg::*;

	logic [MOD_CNT_W-1:0] cnt_q;
	logic phase_end;

	assign phase_end = drive_q ?
		(cnt_q == MOD_CNT_W'(MOD_ON_CYC - 1)) :
		(cnt_q == MOD_CNT_W'(MOD_OFF_CYC - 1));

	always_ff @(posedge clk_sys) begin
		if (rst || !enable) begin
			// Drive off outside proximity
			cnt_q <= '0;
			drive_q <= 1'b0;
		end else if (!mod_en) begin
			// Steady drive
			cnt_q <= '0;
			drive_q <= 1'b1;
		end else if (phase_end) begin
			// Toggle at modulation rate, half on
			cnt_q <= '0;
			drive_q <= !drive_q;
		end else begin
			cnt_q <= cnt_q + MOD_CNT_W'(1);
		end
	end

endmodule

/* dv/lps_fe_model.sv */
// Front end oscillator, charge pulses and interrupt line model
`timescale 1ns/100ps
module lps_fe_model (
	// Bench control
	input wire logic pulses_on,
	// From sequencer
	input wire logic fe_active_q,
	input wire logic int_n_o,
	input wire logic int_n_oe,
	// To sequencer
	output logic osc_clk,
	output logic fe_charge_pulse,
	output wire logic int_n_line
);
	// Free running, unrelated in phase to the system clock
	initial osc_clk = 1'b0;
	always #15.3 osc_clk = ~osc_clk;
	// One pulse per tick saturates any count, so results are full scale
	assign fe_charge_pulse = pulses_on & fe_active_q & ~osc_clk;
	// Pull-up holds the line high once released
	assign int_n_line = int_n_oe ? int_n_o : 1'b1;
endmodule

/* dv/lps_sequencer_properties.sv */
// Port level assertions for the sequencer
`timescale 1ns/100ps
module lps_seq_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	// Front end and pins
	input wire logic fe_active_q,
	input wire logic [1:0] fe_source_q,
	input wire logic [1:0] fe_range_q,
	input wire logic fe_scheme_q,
	input wire logic emitter_drive_pin,
	input wire logic [1:0] led_current_select,
	input wire logic int_n_o,
	input wire logic int_n_oe
);
	import lps_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wire logic cmd1_wr;
	wire logic cmd2_wr;
	logic [1:0] op_q;
	logic [7:0] w2_q;
	assign cmd1_wr = reg_wr && reg_addr == ADDR_CMD1;
	assign cmd2_wr = reg_wr && reg_addr == ADDR_CMD2;
	// Last written images, so consequents see the write, not later data
	always_ff @(posedge clk_sys) begin
		if (cmd1_wr)
			op_q <= reg_wdata[OP_LSB +: 2];
		if (cmd2_wr)
			w2_q <= reg_wdata;
	end
	a_od_low: assert property (int_n_o == 1'b0)
		else $error("interrupt pin driven high");
	a_reset_idle: assert property (
		$fell(rst) |-> !fe_active_q && !emitter_drive_pin && !int_n_oe)
		else $error("not idle after reset");
	a_emit_off: assert property (
		(!fe_active_q || fe_source_q != SRC_PRX) [*3] |-> !emitter_drive_pin)
		else $error("emitter on outside proximity");
	a_flag_hold: assert property ($fell(int_n_oe) |-> $past(cmd1_wr, 2))
		else $error("interrupt dropped without command write");
	a_flag_read: assert property (
		reg_rd && reg_addr == ADDR_CMD1 |=> reg_rdata_q[FLAG_BIT] == int_n_oe)
		else $error("status bit differs from pin");
	a_op_start: assert property (
		cmd1_wr && reg_wdata[OP_LSB +: 2] != 2'h0
		|-> ##[1:3] fe_active_q && fe_source_q == op_q)
		else $error("conversion not started for code");
	a_op_stop: assert property (
		cmd1_wr && reg_wdata[OP_LSB +: 2] == 2'h0 |-> ##[1:3] !fe_active_q)
		else $error("conversion not stopped");
	a_cmd2_fwd: assert property (
		cmd2_wr ##1 !cmd2_wr [*2] |-> fe_range_q == w2_q[1:0]
		&& led_current_select == w2_q[5:4] && fe_scheme_q == w2_q[7])
		else $error("second command fields not applied");
	c_irq: cover property ($rose(int_n_oe));
	c_emit: cover property ($rose(emitter_drive_pin));
	c_done: cover property ($fell(fe_active_q));
endmodule
bind lps_sequencer lps_seq_props lps_seq_props_i (.clk_sys(clk_sys),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.fe_active_q(fe_active_q), .fe_source_q(fe_source_q),
	.fe_range_q(fe_range_q), .fe_scheme_q(fe_scheme_q),
	.emitter_drive_pin(emitter_drive_pin),
	.led_current_select(led_current_select), .int_n_o(int_n_o),
	.int_n_oe(int_n_oe));

/* dv/test_lps_sequencer.sv */
// Directed bench for the light and proximity sequencer
`timescale 1ns/100ps
module test_lps_sequencer;
	import lps_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic pulses_on = 1'b0;
	logic [7:0] reg_rdata_q;
	logic fe_active_q, fe_scheme_q, emitter_drive_pin, int_n_o, int_n_oe;
	logic osc_clk, fe_charge_pulse;
	wire logic int_n_line;
	logic [1:0] fe_source_q, fe_range_q, led_current_select;
	logic [2:0] ops [7] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h4};
	int num_errors = 0;
	int checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	lps_sequencer lps_sequencer_i (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .osc_clk(osc_clk),
		.fe_charge_pulse(fe_charge_pulse), .fe_active_q(fe_active_q),
		.fe_source_q(fe_source_q), .fe_range_q(fe_range_q),
		.fe_scheme_q(fe_scheme_q), .emitter_drive_pin(emitter_drive_pin),
		.led_current_select(led_current_select), .int_n_i(int_n_line),
		.int_n_o(int_n_o), .int_n_oe(int_n_oe));
	lps_fe_model lps_fe_model_i (.pulses_on(pulses_on),
		.fe_active_q(fe_active_q), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
		.osc_clk(osc_clk), .fe_charge_pulse(fe_charge_pulse),
		.int_n_line(int_n_line));
	task automatic give_verdict();
		if (num_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_q;
	endtask
	task automatic wr16(logic [2:0] a, logic [15:0] d);
		wr(a, d[7:0]);
		wr(a + 3'h1, d[15:8]);
	endtask
	task automatic rd16(logic [2:0] a, output logic [15:0] d);
		rd(a, d[7:0]);
		rd(a + 3'h1, d[15:8]);
	endtask
	task automatic wait_cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Bounded wait for the conversion to finish
	task automatic wait_idle();
		int i;
		wait_cyc(3);
		for (i = 0; i < 30000 && fe_active_q !== 1'b0; i++)
			wait_cyc(1);
		if (i == 30000) begin
			num_errors++;
			$display("[FAIL] %0t ns: conversion never ended", $time);
			give_verdict();
		end
	endtask
	task automatic run_len(logic lvl, output int n);
		for (n = 0; n < 2000 && emitter_drive_pin === lvl; n++)
			wait_cyc(1);
		if (n == 2000) begin
			num_errors++;
			$display("[FAIL] %0t ns: emitter level never changed", $time);
			give_verdict();
		end
	endtask
	initial begin
		logic [15:0] v;
		logic [7:0] b;
		logic [2:0] e;
		int i;
		int n;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd16(ADDR_DATA_LSB, v);
		chk(v, 16'h0000);
		rd(ADDR_CMD1, b);
		chk({b, 7'h00, fe_active_q}, 16'h0000);
		wr(ADDR_DATA_MSB, 8'h5a);
		rd16(ADDR_DATA_LSB, v);
		chk(v, 16'h0000);
		for (i = 0; i < 4; i++) begin
			wr(ADDR_CMD2, {i[0], 1'b0, 2'(i), 2'h3, 2'(i)});
			wait_cyc(2);
			chk({7'h0, fe_scheme_q, 4'h0, led_current_select, fe_range_q},
				{7'h0, i[0], 4'h0, 4'(i * 5)});
		end
		// Every operation code, each stopped by power-down
		for (i = 0; i < 7; i++) begin
			wr(ADDR_CMD1, {ops[i], 5'h00});
			rd(ADDR_CMD1, b);
			e = (ops[i] == OP_RSVD) ? 3'h0 : ops[i];
			chk({10'h0, b[7:5], fe_active_q, fe_source_q},
				{10'h0, e, e[1:0] != 2'h0, e[1:0]});
			wr(ADDR_CMD1, 8'h00);
			wait_cyc(3);
			chk({15'h0, fe_active_q}, 16'h0000);
		end
		// One-shot per mode at 12, 8 and 4 bits, full scale input
		pulses_on <= 1'b1;
		for (i = 1; i < 4; i++) begin
			wr(ADDR_CMD2, {4'h0, 2'(i), 2'h0});
			wr(ADDR_CMD1, {3'(i), 5'h00});
			wait_idle();
			rd16(ADDR_DATA_LSB, v);
			chk(v, 16'hffff >> (4 * i));
			rd(ADDR_CMD1, b);
			chk({13'h0, b[7:5]}, 16'h0000);
		end
		wr(ADDR_CMD1, {OP_IR_CONT, 5'h00});
		wait_cyc(300);
		rd16(ADDR_DATA_LSB, v);
		chk(v, 16'h000f);
		pulses_on <= 1'b0;
		wait_cyc(300);
		rd16(ADDR_DATA_LSB, v);
		chk({v[14:0], fe_active_q}, 16'h0001);
		wr(ADDR_CMD1, 8'h00);
		wait_cyc(3);
		chk({15'h0, fe_active_q}, 16'h0000);
		// Emitter steady, then modulated
		wr(ADDR_CMD2, 8'h08);
		wr(ADDR_CMD1, {OP_PRX_ONCE, 5'h00});
		wait_cyc(20);
		run_len(1'b1, n);
		chk({15'h0, n > 1000}, 16'h0001);
		wait_idle();
		chk({15'h0, emitter_drive_pin}, 16'h0000);
		wr(ADDR_CMD2, 8'h48);
		wr(ADDR_CMD1, {OP_PRX_ONCE, 5'h00});
		wait_cyc(5);
		run_len(1'b1, n);
		run_len(1'b0, n);
		run_len(1'b1, n);
		chk(n[15:0], 16'(MOD_ON_CYC));
		run_len(1'b0, n);
		chk(n[15:0], 16'(MOD_OFF_CYC));
		wait_idle();
		// Threshold interrupt, persistence and clearing
		wr(ADDR_CMD2, 8'h0c);
		wr16(ADDR_TH_LSB, 16'h000a);
		pulses_on <= 1'b1;
		wr(ADDR_CMD1, 8'h20);
		wait_idle();
		wait_cyc(3);
		rd(ADDR_CMD1, b);
		chk({14'h0, int_n_line, b[FLAG_BIT]}, 16'h0001);
		wait_cyc(200);
		chk({15'h0, int_n_line}, 16'h0000);
		wr(ADDR_CMD1, 8'h00);
		wait_cyc(3);
		rd(ADDR_CMD1, b);
		chk({14'h0, int_n_line, b[FLAG_BIT]}, 16'h0002);
		wr16(ADDR_TH_LSB, 16'hffff);
		wr16(ADDR_TL_LSB, 16'h0005);
		wr(ADDR_CMD1, 8'h20);
		wait_idle();
		wait_cyc(3);
		chk({15'h0, int_n_line}, 16'h0001);
		pulses_on <= 1'b0;
		wr(ADDR_CMD1, 8'ha1);
		wait_cyc(350);
		chk({15'h0, int_n_line}, 16'h0001);
		wait_cyc(130);
		chk({15'h0, int_n_line}, 16'h0000);
		wr(ADDR_CMD1, 8'h00);
		wait_cyc(3);
		chk({15'h0, int_n_line}, 16'h0001);
		give_verdict();
	end
endmodule
